// >>> shared/wsb_consts.svh
// Timing and field constants for the wide slot memory bus controller.
// Assumes a 100 MHz system clock; included by the package and the RTL.
`ifndef WSB_CONSTS_SVH
`define WSB_CONSTS_SVH
`define WSB_CLK_PERIOD_NS 10
`define WSB_SLOT_DIV 2
`define WSB_REFRESH_NS 14000
`define WSB_REFRESH_CYC (`WSB_REFRESH_NS / `WSB_CLK_PERIOD_NS)
`define WSB_ROW_BITS 9
`define WSB_ADDR_BITS 32
`define WSB_DATA_BITS 32
`define WSB_LANES 4
`define WSB_WAIT_LIMIT 16
`endif

// >>> shared/wsb_pkg.sv
// Types shared by the wide slot memory bus controller files.
// Assumes wsb_consts.svh is on the include path.
`include "wsb_consts.svh"
package wsb_pkg;
  typedef struct packed {
    logic [`WSB_ADDR_BITS-1:0] addr;
    logic [`WSB_DATA_BITS-1:0] wdata;
    logic write;
  } wsb_req_t;

  typedef struct packed {
    logic [`WSB_DATA_BITS-1:0] rdata;
    logic parity_err;
    logic no_answer;
  } wsb_rsp_t;

  typedef enum logic [2:0] {
    WSB_IDLE = 3'b000,
    WSB_CMD = 3'b001,
    WSB_WAIT = 3'b010,
    WSB_END = 3'b011,
    WSB_REFR = 3'b100
  } wsb_state_t;
endpackage : wsb_pkg

// >>> rtl/wsb_parity.sv
// Per byte lane odd parity generator and comparator.
// Pure combinational; used for both outgoing and returned parity.
`timescale 1ns/1ps
`include "wsb_consts.svh"
module wsb_parity
  import wsb_pkg::*;
#(
  parameter int LANES = `WSB_LANES
)
(
  // Data in
  input wire logic [8*LANES-1:0] data,
  // Parity out and check
  input wire logic [LANES-1:0] par_in,
  output logic [LANES-1:0] par_gen,
  output logic mismatch
);
  if (LANES < 1)
  begin : g_bad_param
    $error("wsb_parity: LANES must be at least one");
  end
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // Odd parity per byte lane, bit n covers bits 8n..8n+7.
      assign par_gen[g] = ~^data[8*g +: 8];
    end
  endgenerate
  assign mismatch = |(par_gen ^ par_in);
endmodule : wsb_parity

// >>> rtl/wsb_slot_ctrl.sv
// System-side controller of the wide 32-bit memory expansion slot.
// Assumes a 100 MHz clk; card-side pins arrive asynchronously.
`timescale 1ns/1ps
`include "wsb_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Slot cycle clock runs at half the base clock rate.
// - Data lines bidirectional: system drives on writes, card on reads.
// - System presents four parity bits with the write data it supplies.
// - Card returns parity on reads; system checks it and raises parity NMI.
// - Bus-granted output high while the bus is released to another master.
// - Memory command high only while address is valid and transfer runs.
// - Write indicator low during writes, high during reads.
// - Refresh cycle asserts refresh low with row on low nine address bits.
// - Refresh cycles repeat about every fourteen to fifteen microseconds while the bus is not granted to another master.
module wsb_slot_ctrl
  import wsb_pkg::*;
#(
  parameter int REFRESH_CYC = `WSB_REFRESH_CYC,
  parameter int WAIT_LIMIT = `WSB_WAIT_LIMIT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Processor side request
  input wire logic req_valid,
  output logic req_ready,
  input wire wsb_req_t req,
  output logic rsp_valid,
  output wsb_rsp_t rsp,
  // Bus hand-off to an alternate master
  input wire logic alt_master_hold,
  output logic bus_granted_to_alt_master,
  // Slot pins
  output logic slot_clk,
  output logic [`WSB_ADDR_BITS-1:0] slot_addr,
  output logic [`WSB_DATA_BITS-1:0] slot_data_o,
  output logic slot_data_oe_n,
  input wire logic [`WSB_DATA_BITS-1:0] slot_data_i,
  output logic [`WSB_LANES-1:0] parity_to_card,
  input wire logic [`WSB_LANES-1:0] parity_from_card,
  input wire logic card_select_ack_n,
  output logic memory_command_valid,
  output logic write_cycle_n,
  output logic refresh_n,
  output logic parity_nmi
);
  // The wait counter is eight bits wide, so longer bounds are refused here.
  if (REFRESH_CYC < 8 || WAIT_LIMIT < 2 || WAIT_LIMIT > 255)
  begin : g_bad_param
    $error("wsb_slot_ctrl: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second.
  logic ack_s1_r, ack_s2_r;
  logic [`WSB_DATA_BITS-1:0] rd_s1_r, rd_s2_r;
  logic [`WSB_LANES-1:0] po_s1_r, po_s2_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      rd_s1_r <= '0;
      rd_s2_r <= '0;
      po_s1_r <= '0;
      po_s2_r <= '0;
    end
    else if (ce)
    begin
      ack_s1_r <= card_select_ack_n;
      ack_s2_r <= ack_s1_r;
      rd_s1_r <= slot_data_i;
      rd_s2_r <= rd_s1_r;
      po_s1_r <= parity_from_card;
      po_s2_r <= po_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot clock and refresh interval.
  logic slot_clk_r;
  logic [$clog2(REFRESH_CYC+1)-1:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_pend_r, ref_pend_nxt;
  logic [`WSB_ROW_BITS-1:0] row_r, row_nxt;
  wire ref_tick = (ref_cnt_r == '0);
  wire slot_edge = slot_clk_r; // Transitions advance as the slot clock falls, at the end of its high phase.

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state.
  wsb_state_t state_r, state_nxt;
  wsb_req_t cur_r, cur_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic grant_r, grant_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  wsb_rsp_t rsp_r, rsp_nxt;
  logic nmi_r, nmi_nxt;
  logic [`WSB_LANES-1:0] wpar;
  logic rd_mismatch;

  wsb_parity #(.LANES(`WSB_LANES)) u_wpar (
    .data(cur_r.wdata),
    .par_in('0),
    .par_gen(wpar),
    .mismatch()
  );
  wsb_parity #(.LANES(`WSB_LANES)) u_rpar (
    .data(rd_s2_r),
    .par_in(po_s2_r),
    .par_gen(),
    .mismatch(rd_mismatch)
  );

  wire is_idle = (state_r == WSB_IDLE);
  wire ack_seen = ~ack_s2_r;
  wire start_ref = is_idle && slot_edge && ref_pend_r && !grant_r;
  wire start_xfer = is_idle && slot_edge && !ref_pend_r && !grant_r && req_valid;
  // Ready is withheld while the clock enable freezes state, or a request would be lost.
  assign req_ready = start_xfer && ce;

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    wait_nxt = wait_r;
    grant_nxt = grant_r;
    rsp_valid_nxt = 1'b0;
    rsp_nxt = rsp_r;
    nmi_nxt = nmi_r;
    row_nxt = row_r;
    ref_cnt_nxt = ref_tick ? ($bits(ref_cnt_r))'(REFRESH_CYC - 1) : ref_cnt_r - 1'b1;
    ref_pend_nxt = ref_pend_r | ref_tick;
    case (state_r)
      WSB_IDLE:
      begin
        // Hand-off only between cycles, never on the edge that starts one.
        // Otherwise the bus would be granted away while a command is on it.
        if (slot_edge && !start_ref && !start_xfer)
          grant_nxt = alt_master_hold;
        if (start_ref)
        begin
          state_nxt = WSB_REFR;
          ref_pend_nxt = ref_tick;
        end
        else if (start_xfer)
        begin
          cur_nxt = req;
          wait_nxt = '0;
          state_nxt = WSB_CMD;
        end
      end
      WSB_CMD:
      begin
        if (slot_edge)
          state_nxt = WSB_WAIT;
      end
      WSB_WAIT:
      begin
        // A card that never acknowledges ends the cycle after a bound.
        if (slot_edge)
        begin
          wait_nxt = wait_r + 8'h01;
          if (ack_seen || wait_r == 8'(WAIT_LIMIT - 1))
            state_nxt = WSB_END;
        end
      end
      WSB_END:
      begin
        rsp_valid_nxt = 1'b1;
        rsp_nxt.rdata = cur_r.write ? '0 : rd_s2_r;
        rsp_nxt.no_answer = !ack_seen;
        rsp_nxt.parity_err = !cur_r.write && ack_seen && rd_mismatch;
        if (!cur_r.write && ack_seen && rd_mismatch)
          nmi_nxt = 1'b1;
        state_nxt = WSB_IDLE;
      end
      WSB_REFR:
      begin
        if (slot_edge)
        begin
          row_nxt = row_r + 1'b1;
          state_nxt = WSB_IDLE;
        end
      end
      default:
      begin
        state_nxt = WSB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slot_clk_r <= 1'b0;
      ref_cnt_r <= '0;
      ref_pend_r <= 1'b0;
      row_r <= '0;
      state_r <= WSB_IDLE;
      cur_r <= '0;
      wait_r <= '0;
      grant_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
      nmi_r <= 1'b0;
    end
    else if (ce)
    begin
      slot_clk_r <= ~slot_clk_r;
      ref_cnt_r <= ref_cnt_nxt;
      ref_pend_r <= ref_pend_nxt;
      row_r <= row_nxt;
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      wait_r <= wait_nxt;
      grant_r <= grant_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive.
  wire in_xfer = (state_r == WSB_CMD) || (state_r == WSB_WAIT) || (state_r == WSB_END);
  wire in_ref = (state_r == WSB_REFR);
  assign slot_clk = slot_clk_r;
  // Address is system-owned; refresh puts the row on the low bits.
  assign slot_addr = in_ref ? {{(`WSB_ADDR_BITS-`WSB_ROW_BITS){1'b0}}, row_r}
                            : cur_r.addr;
  assign memory_command_valid = in_xfer;
  assign write_cycle_n = !(in_xfer && cur_r.write);
  assign refresh_n = !in_ref;
  assign slot_data_o = cur_r.wdata;
  assign slot_data_oe_n = !(in_xfer && cur_r.write);
  assign parity_to_card = wpar;
  assign bus_granted_to_alt_master = grant_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign parity_nmi = nmi_r;
endmodule : wsb_slot_ctrl

// >>> test/wsb_slot_ctrl_assertions.sv
// Pin-level checks for the wide slot controller.
// Assumes it is bound onto wsb_slot_ctrl with ce held high.
`timescale 1ns/1ps
module wsb_chk
  import wsb_pkg::*;
#(
  parameter int REFRESH_CYC = 40
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Observed outputs
  input wire logic rsp_valid,
  input wire logic bus_granted_to_alt_master,
  input wire logic slot_clk,
  input wire logic [31:0] slot_addr,
  input wire logic [31:0] slot_data_o,
  input wire logic slot_data_oe_n,
  input wire logic [3:0] parity_to_card,
  input wire logic memory_command_valid,
  input wire logic write_cycle_n,
  input wire logic refresh_n,
  input wire logic parity_nmi
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] gap_r;
  // A transfer in progress may delay refresh, so the gap gets some slack.
  always_ff @(posedge clk or posedge rst)
    if (rst) gap_r <= '0;
    else gap_r <= refresh_n ? gap_r + 16'h1 : '0;
  slot_half_a: assert property (ce |=> slot_clk != $past(slot_clk))
    else $error("slot clock not toggling");
  lane_par_a: assert property (memory_command_valid && !write_cycle_n |-> parity_to_card ==
    {~^slot_data_o[31:24], ~^slot_data_o[23:16], ~^slot_data_o[15:8], ~^slot_data_o[7:0]})
    else $error("write parity wrong");
  grant_quiet_a: assert property (bus_granted_to_alt_master |-> !memory_command_valid)
    else $error("command while granted");
  wr_drive_a: assert property (memory_command_valid && !write_cycle_n |-> !slot_data_oe_n)
    else $error("write data not driven");
  rd_release_a: assert property (memory_command_valid && write_cycle_n |-> slot_data_oe_n)
    else $error("data driven on read");
  addr_hold_a: assert property (memory_command_valid && $past(memory_command_valid)
    |-> $stable(slot_addr)) else $error("address moved in transfer");
  refr_row_a: assert property (!refresh_n |-> slot_addr[31:9] == 23'h0 && !memory_command_valid)
    else $error("refresh address wrong");
  refr_gap_a: assert property (gap_r < REFRESH_CYC + 64)
    else $error("refresh overdue");
  nmi_sticky_a: assert property (parity_nmi |=> parity_nmi)
    else $error("parity nmi dropped");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than a cycle");
endmodule : wsb_chk
bind wsb_slot_ctrl wsb_chk #(.REFRESH_CYC(REFRESH_CYC)) i_wsb_chk (.clk, .rst, .ce, .rsp_valid,
  .bus_granted_to_alt_master, .slot_clk, .slot_addr, .slot_data_o, .slot_data_oe_n,
  .parity_to_card, .memory_command_valid, .write_cycle_n, .refresh_n, .parity_nmi);

// >>> test/wsb_card_model.sv
// Memory card model for the wide slot: four words at addresses 0x1xxx_xxxx.
// Assumes the system side drives address and command pins.
`timescale 1ns/1ps
module wsb_card
(
  // Clock and controls
  input wire logic clk,
  input wire logic slow,
  input wire logic [3:0] bad_par,
  // Slot pins; address is input only here
  input wire logic [31:0] slot_addr,
  input wire logic memory_command_valid,
  input wire logic write_cycle_n,
  input wire logic [31:0] slot_data_o,
  input wire logic [3:0] parity_to_card,
  output logic [31:0] slot_data_i,
  output logic [3:0] parity_from_card,
  output logic card_select_ack_n
);
  logic [35:0] mem [4];
  logic [35:0] last_r = 36'h0;
  logic [3:0] wait_r;
  wire sel = slot_addr[31:28] == 4'h1;
  wire ans = memory_command_valid && sel && wait_r >= (slow ? 4'h6 : 4'h1);
  wire rd = ans && write_cycle_n;
  assign card_select_ack_n = !ans;
  // Released lines show a changing pattern, never the last value.
  assign {parity_from_card, slot_data_i} = rd ? mem[slot_addr[3:2]] ^ {bad_par, 32'h0} : ~last_r;
  always @(posedge clk)
  begin
    last_r <= {parity_from_card, slot_data_i};
    wait_r <= !memory_command_valid ? 4'h0 : wait_r + {3'h0, wait_r != 4'hF};
    if (memory_command_valid && sel && !write_cycle_n)
      mem[slot_addr[3:2]] <= {parity_to_card, slot_data_o};
  end
endmodule : wsb_card

// >>> test/wsb_slot_ctrl_tb.sv
// Self-checking bench for the wide slot controller with a card model.
// Assumes a short refresh interval of 40 cycles.
`timescale 1ns/1ps
module wsb_slot_ctrl_tb;
  import wsb_pkg::*;
  localparam int RCYC = 40;
  logic clk, rst, req_valid, req_ready, rsp_valid, alt_master_hold, bus_granted_to_alt_master;
  logic slot_clk, slot_data_oe_n, card_select_ack_n, memory_command_valid, write_cycle_n;
  logic refresh_n, parity_nmi, slow;
  logic [3:0] bad_par, parity_to_card, parity_from_card;
  logic [31:0] slot_addr, slot_data_o, slot_data_i;
  wsb_req_t req;
  wsb_rsp_t rsp;
  int fail_count = 0, check_count = 0, cyc = 0;
  wsb_slot_ctrl #(.REFRESH_CYC(RCYC)) i_wsb_slot_ctrl (.clk, .rst, .ce(1'b1), .req_valid,
    .req_ready, .req, .rsp_valid, .rsp, .alt_master_hold, .bus_granted_to_alt_master, .slot_clk,
    .slot_addr, .slot_data_o, .slot_data_oe_n, .slot_data_i, .parity_to_card, .parity_from_card,
    .card_select_ack_n, .memory_command_valid, .write_cycle_n, .refresh_n, .parity_nmi);
  wsb_card i_wsb_card (.clk, .slow, .bad_par, .slot_addr, .memory_command_valid, .write_cycle_n,
    .slot_data_o, .parity_to_card, .slot_data_i, .parity_from_card, .card_select_ack_n);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
    int i;
    @(negedge clk);
    req = '{addr: a, wdata: d, write: w};
    req_valid = 1'b1;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) @(negedge clk);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
  endtask : xfer
  task automatic t_refresh;
    int i, n;
    logic [8:0] row;
    for (i = 0; i < 200 && refresh_n !== 1'b0; i++) @(negedge clk);
    row = slot_addr[8:0];
    chk("refresh high addr", 32'h0, {9'h0, slot_addr[31:9]});
    for (n = 0; n < 200 && refresh_n !== 1'b1; n++) @(negedge clk);
    for (; n < 200 && refresh_n !== 1'b0; n++) @(negedge clk);
    chk("next row", 32'(row + 9'h1), {23'h0, slot_addr[8:0]});
    chk("refresh gap", 32'h1, {31'h0, n >= RCYC - 4 && n <= RCYC + 4});
  endtask : t_refresh
  task automatic t_wr_rd;
    xfer(32'h1000_0004, 32'h0102_0307, 1'b1);
    xfer(32'h1000_0008, 32'hFF00_807F, 1'b1);
    xfer(32'h1000_0004, 32'h0, 1'b0);
    chk("rdata", 32'h0102_0307, rsp.rdata);
    chk("perr", 32'h0, {31'h0, rsp.parity_err});
    slow = 1'b1;
    xfer(32'h1000_0008, 32'h0, 1'b0);
    chk("rdata slow", 32'hFF00_807F, rsp.rdata);
    chk("perr slow", 32'h0, {31'h0, rsp.parity_err});
    slow = 1'b0;
    xfer(32'h2000_0000, 32'h0, 1'b0);
    chk("no answer", 32'h1, {31'h0, rsp.no_answer});
    chk("nmi quiet", 32'h0, {31'h0, parity_nmi});
  endtask : t_wr_rd
  task automatic t_grant;
    int i;
    @(negedge clk);
    alt_master_hold = 1'b1;
    for (i = 0; i < 60 && bus_granted_to_alt_master !== 1'b1; i++) @(negedge clk);
    chk("grant", 32'h1, {31'h0, bus_granted_to_alt_master});
    chk("command idle", 32'h0, {31'h0, memory_command_valid});
    alt_master_hold = 1'b0;
    for (i = 0; i < 60 && bus_granted_to_alt_master !== 1'b0; i++) @(negedge clk);
    chk("grant off", 32'h0, {31'h0, bus_granted_to_alt_master});
  endtask : t_grant
  task automatic t_parity;
    bad_par = 4'h4;
    xfer(32'h1000_0004, 32'h0, 1'b0);
    chk("perr lane2", 32'h1, {31'h0, rsp.parity_err});
    chk("nmi", 32'h1, {31'h0, parity_nmi});
    bad_par = 4'h0;
    xfer(32'h1000_0004, 32'h0, 1'b0);
    chk("perr clean", 32'h0, {31'h0, rsp.parity_err});
    chk("nmi sticky", 32'h1, {31'h0, parity_nmi});
  endtask : t_parity
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("nmi cleared", 32'h0, {31'h0, parity_nmi});
    chk("reset command", 32'h0, {31'h0, memory_command_valid});
    chk("reset write", 32'h1, {31'h0, write_cycle_n});
    chk("reset refresh", 32'h1, {31'h0, refresh_n});
    chk("reset grant", 32'h0, {31'h0, bus_granted_to_alt_master});
    rst = 1'b0;
    xfer(32'h1000_0004, 32'h0, 1'b0);
    chk("rdata after reset", 32'h0102_0307, rsp.rdata);
    chk("nmi after reset", 32'h0, {31'h0, parity_nmi});
  endtask : t_reset
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    alt_master_hold = 1'b0;
    slow = 1'b0;
    bad_par = 4'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_refresh;
    t_wr_rd;
    t_grant;
    t_parity;
    t_reset;
    tally_and_finish;
  end
endmodule : wsb_slot_ctrl_tb
